// ---- erw_pkg.sv ----
// Package of constants for the external bus READY wait control
// Behaviour
// [RL1] Capture read data on the strobe-ending edge
// [RL2] Address moves before strobe end never matter
// [RL3] External data may change after strobe rise
// [RL4] READY lengthens cycles; polarity is selectable
// [RL5] Synchronous READY gives the shortest cycle
// [RL6] Asynchronous READY adds a synchronising stage
// [RL7] Async READY held one period plus setup
// [RL8] External READY may drop after strobe rise
// [RL9] READY withdrawn before next cycle's sample
// [RL10] Sample point follows programmed phase lengths
// [RL11] Inactive READY inserts a waitstate, resamples
// [RL12] Active READY ends the running bus cycle
// [RL13] Async sample point later than sync one
// [RL14] Five programmable phases; access 1 to 32
// [RL15] External READY may lengthen the access phase
// [RL16] READY ignored outside access, before minimum
// [RL17] Async chain feeds the same termination logic
`default_nettype none
package erw_pkg;
    // ------------------------------------------------
    // Register map
    // ------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_TIMING = 8'h04;
    localparam logic [7:0] OFS_ADDR = 8'h08;
    localparam logic [7:0] OFS_WDATA = 8'h0c;
    localparam logic [7:0] OFS_CMD = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_RDATA = 8'h18;
    // ------------------------------------------------
    // Fields
    // ------------------------------------------------
    localparam int CTRL_RDY_EN = 0;
    localparam int CTRL_RDY_POL = 1;
    localparam int CTRL_RDY_ASYNC = 2;
    localparam int CMD_RNW = 0;
    localparam int TM_AB = 0;
    localparam int TM_C = 1;
    localparam int TM_D = 3;
    localparam int TM_E = 4;
    localparam int TM_F = 9;
    localparam int ST_BUSY = 0;
    localparam int ST_WCNT = 8;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [10:0] TIMING_RST = 11'h000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [5:0] {
        PH_IDLE = 6'h01,
        PH_AB = 6'h02,
        PH_C = 6'h04,
        PH_D = 6'h08,
        PH_E = 6'h10,
        PH_F = 6'h20
    } erw_phase_e;
endpackage : erw_pkg
`default_nettype wire

// ---- erw_ready_ctrl.sv ----
// External bus cycle engine with READY wait control and AXI4-Lite access
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module erw_ready_ctrl (
    // System clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // External bus, link clock domain
    input wire logic link_clk,
    output logic bus_reference_clock,
    output logic bus_cs_n,
    output logic bus_rd_n,
    output logic bus_wr_n,
    output logic [23:0] bus_addr,
    output logic [15:0] bus_dout,
    output logic bus_doe_n,
    input wire logic [15:0] bus_din,
    input wire logic bus_ready
);
    // ------------------------------------------------
    // Register slave
    // ------------------------------------------------
    logic aw_full_r, w_full_r, bvalid_r, rvalid_r, busy_r, start_tgl_r;
    logic [7:0] awaddr_r;
    logic [31:0] wd_r, rdata_r;
    logic [3:0] wstrb_r;
    logic [1:0] bresp_r, rresp_r;
    logic [2:0] ctrl_r;
    logic [10:0] timing_r;
    logic [23:0] addr_r;
    logic [15:0] wdata_r, rd_cap_r;
    logic rnw_r;
    logic [7:0] wcnt_cap_r;
    logic as1_r, as2_r, as3_r;
    logic done_tgl_r;
    logic [15:0] rdata_l_r;
    logic [7:0] wcnt_l_r;

    wire do_wr = aw_full_r & w_full_r & ~bvalid_r;
    wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
                         {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    wire wr_ctrl = awaddr_r == erw_pkg::OFS_CTRL;
    wire wr_tm = awaddr_r == erw_pkg::OFS_TIMING;
    wire wr_addr = awaddr_r == erw_pkg::OFS_ADDR;
    wire wr_wd = awaddr_r == erw_pkg::OFS_WDATA;
    wire wr_cmd = awaddr_r == erw_pkg::OFS_CMD;
    wire wr_ro = awaddr_r == erw_pkg::OFS_STATUS
               || awaddr_r == erw_pkg::OFS_RDATA;
    wire wr_map = wr_ctrl | wr_tm | wr_addr | wr_wd | wr_cmd | wr_ro;
    // Config is read by the link side mid-cycle, so it is frozen while busy
    wire wr_ok = wr_map & ~wr_ro & ~busy_r;
    wire [31:0] ctrl_m = ({29'h0, ctrl_r} & ~wmask) | (wd_r & wmask);
    wire [31:0] tm_m = ({21'h0, timing_r} & ~wmask) | (wd_r & wmask);
    wire [31:0] addr_m = ({8'h0, addr_r} & ~wmask) | (wd_r & wmask);
    wire [31:0] wdt_m = ({16'h0, wdata_r} & ~wmask) | (wd_r & wmask);
    wire cmd_go = do_wr & wr_cmd & ~busy_r & wstrb_r[0];
    wire done_p = as2_r ^ as3_r;

    assign s_axi_awready = ~aw_full_r & ~bvalid_r;
    assign s_axi_wready = ~w_full_r & ~bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= erw_pkg::RESP_OKAY;
            awaddr_r <= 8'h00;
            wd_r <= 32'h0;
            wstrb_r <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_full_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_full_r <= 1'b1;
                wd_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_wr)
            begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? erw_pkg::RESP_OKAY : erw_pkg::RESP_SLVERR;
            end
            else if (s_axi_bready)
                bvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_r <= erw_pkg::CTRL_RST;
            timing_r <= erw_pkg::TIMING_RST;
            addr_r <= 24'h0;
            wdata_r <= 16'h0;
            rnw_r <= 1'b0;
        end
        else if (do_wr && wr_ok)
        begin
            if (wr_ctrl)
                ctrl_r <= ctrl_m[2:0];
            if (wr_tm)
                timing_r <= tm_m[10:0];
            if (wr_addr)
                addr_r <= addr_m[23:0];
            if (wr_wd)
                wdata_r <= wdt_m[15:0];
            if (cmd_go)
                rnw_r <= wd_r[erw_pkg::CMD_RNW];
        end
    end

    // Handshake: start toggles out, done toggles back with results stable
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            start_tgl_r <= 1'b0;
            busy_r <= 1'b0;
            as1_r <= 1'b0;
            as2_r <= 1'b0;
            as3_r <= 1'b0;
            rd_cap_r <= 16'h0;
            wcnt_cap_r <= 8'h00;
        end
        else
        begin
            as1_r <= done_tgl_r;
            as2_r <= as1_r;
            as3_r <= as2_r;
            if (cmd_go)
            begin
                start_tgl_r <= ~start_tgl_r;
                busy_r <= 1'b1;
            end
            else if (done_p)
                busy_r <= 1'b0;
            if (done_p)
            begin
                rd_cap_r <= rdata_l_r;
                wcnt_cap_r <= wcnt_l_r;
            end
        end
    end

    wire [31:0] status_v = {16'h0, wcnt_cap_r, 7'h0, busy_r};
    wire rd_hit = s_axi_araddr == erw_pkg::OFS_CTRL
               || s_axi_araddr == erw_pkg::OFS_TIMING
               || s_axi_araddr == erw_pkg::OFS_ADDR
               || s_axi_araddr == erw_pkg::OFS_WDATA
               || s_axi_araddr == erw_pkg::OFS_CMD
               || s_axi_araddr == erw_pkg::OFS_STATUS
               || s_axi_araddr == erw_pkg::OFS_RDATA;
    wire [31:0] rd_mux =
        s_axi_araddr == erw_pkg::OFS_CTRL ? {29'h0, ctrl_r} :
        s_axi_araddr == erw_pkg::OFS_TIMING ? {21'h0, timing_r} :
        s_axi_araddr == erw_pkg::OFS_ADDR ? {8'h0, addr_r} :
        s_axi_araddr == erw_pkg::OFS_WDATA ? {16'h0, wdata_r} :
        s_axi_araddr == erw_pkg::OFS_CMD ? {31'h0, rnw_r} :
        s_axi_araddr == erw_pkg::OFS_STATUS ? status_v :
        s_axi_araddr == erw_pkg::OFS_RDATA ? {16'h0, rd_cap_r} : 32'h0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= erw_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= rd_hit ? erw_pkg::RESP_OKAY : erw_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_r <= 1'b0;
    end

    // ------------------------------------------------
    // Link domain: bus cycle engine
    // ------------------------------------------------
    logic lrs1_r, lrst_n_r, ls1_r, ls2_r, ls3_r;
    logic rdy_s_r, rdy_m_r, rdy_a_r;
    logic [4:0] cnt_r, cnt_nxt;
    erw_pkg::erw_phase_e ph_r, ph_nxt;
    logic cs_n_r, rd_n_r, wr_n_r, doe_n_r;
    logic [23:0] baddr_r;
    logic [15:0] bdout_r;

    // Reference clock handed to the external module for synchronous READY
    assign bus_reference_clock = link_clk;
    assign bus_cs_n = cs_n_r;
    assign bus_rd_n = rd_n_r;
    assign bus_wr_n = wr_n_r;
    assign bus_addr = baddr_r;
    assign bus_dout = bdout_r;
    assign bus_doe_n = doe_n_r;

    // Settings are read directly: frozen by the busy interlock
    wire [1:0] len_c = timing_r[erw_pkg::TM_C +: 2];
    wire len_d = timing_r[erw_pkg::TM_D];
    wire [4:0] len_e = timing_r[erw_pkg::TM_E +: 5];
    wire [1:0] len_f = timing_r[erw_pkg::TM_F +: 2];
    wire rdy_en = ctrl_r[erw_pkg::CTRL_RDY_EN];
    wire rdy_pol = ctrl_r[erw_pkg::CTRL_RDY_POL];
    wire rdy_async = ctrl_r[erw_pkg::CTRL_RDY_ASYNC];
    wire start_p = ls2_r ^ ls3_r;
    wire cnt_z = cnt_r == 5'h00;
    wire rdy_sel = rdy_async ? rdy_a_r : rdy_s_r; // RL13 RL17
    wire rdy_act = rdy_sel == rdy_pol; // RL4
    // Minimum access time first, then READY decides
    wire rdy_ok = ~rdy_en | rdy_act; // RL15 RL16
    wire e_end = ph_r == erw_pkg::PH_E && cnt_z && rdy_ok; // RL12
    wire e_wait = ph_r == erw_pkg::PH_E && cnt_z && ~rdy_ok; // RL11

    always_comb
    begin
        ph_nxt = ph_r;
        cnt_nxt = cnt_r - 5'h01;
        case (ph_r)
            erw_pkg::PH_IDLE:
            begin
                cnt_nxt = {4'h0, timing_r[erw_pkg::TM_AB]}; // RL14
                if (start_p)
                    ph_nxt = erw_pkg::PH_AB;
            end
            erw_pkg::PH_AB, erw_pkg::PH_C, erw_pkg::PH_D:
            begin
                if (cnt_z)
                begin
                    // Zero-length phases are skipped
                    if (ph_r == erw_pkg::PH_AB && len_c != 2'h0)
                    begin
                        ph_nxt = erw_pkg::PH_C;
                        cnt_nxt = {3'h0, len_c - 2'h1};
                    end
                    else if (ph_r != erw_pkg::PH_D && len_d)
                    begin
                        ph_nxt = erw_pkg::PH_D;
                        cnt_nxt = 5'h00;
                    end
                    else
                    begin
                        ph_nxt = erw_pkg::PH_E;
                        cnt_nxt = len_e; // RL10
                    end
                end
            end
            erw_pkg::PH_E:
            begin
                if (e_wait)
                    cnt_nxt = 5'h00; // RL11
                else if (e_end && len_f != 2'h0)
                begin
                    ph_nxt = erw_pkg::PH_F;
                    cnt_nxt = {3'h0, len_f - 2'h1};
                end
                else if (e_end)
                    ph_nxt = erw_pkg::PH_IDLE;
            end
            erw_pkg::PH_F:
            begin
                if (cnt_z)
                    ph_nxt = erw_pkg::PH_IDLE;
            end
            default:
                ph_nxt = erw_pkg::PH_IDLE;
        endcase
    end

    always_ff @(posedge link_clk)
    begin
        lrs1_r <= aresetn;
        lrst_n_r <= lrs1_r;
    end

    always_ff @(posedge link_clk)
    begin
        if (!lrst_n_r)
        begin
            ls1_r <= 1'b0;
            ls2_r <= 1'b0;
            ls3_r <= 1'b0;
            rdy_s_r <= 1'b0;
            rdy_m_r <= 1'b0;
            rdy_a_r <= 1'b0;
            ph_r <= erw_pkg::PH_IDLE;
            cnt_r <= 5'h00;
        end
        else
        begin
            ls1_r <= start_tgl_r;
            ls2_r <= ls1_r;
            ls3_r <= ls2_r;
            rdy_s_r <= bus_ready; // RL5
            rdy_m_r <= bus_ready; // RL6
            rdy_a_r <= rdy_m_r; // RL6 RL17
            ph_r <= ph_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge link_clk)
    begin
        if (!lrst_n_r)
        begin
            cs_n_r <= 1'b1;
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            doe_n_r <= 1'b1;
            baddr_r <= 24'h0;
            bdout_r <= 16'h0;
            rdata_l_r <= 16'h0;
            wcnt_l_r <= 8'h00;
            done_tgl_r <= 1'b0;
        end
        else
        begin
            cs_n_r <= ph_nxt == erw_pkg::PH_IDLE;
            rd_n_r <= ~(ph_nxt == erw_pkg::PH_E && rnw_r);
            wr_n_r <= ~(ph_nxt == erw_pkg::PH_E && !rnw_r);
            doe_n_r <= ~(!rnw_r && (ph_nxt == erw_pkg::PH_D
                     || ph_nxt == erw_pkg::PH_E || ph_nxt == erw_pkg::PH_F));
            if (start_p && ph_r == erw_pkg::PH_IDLE)
            begin
                baddr_r <= addr_r; // RL2
                bdout_r <= wdata_r;
                wcnt_l_r <= 8'h00;
            end
            if (e_wait)
                wcnt_l_r <= wcnt_l_r + 8'h01;
            // Same edge as strobe rise; later data is not trusted
            if (e_end && rnw_r)
                rdata_l_r <= bus_din; // RL1 RL3
            if (ph_r != erw_pkg::PH_IDLE && ph_nxt == erw_pkg::PH_IDLE)
                done_tgl_r <= ~done_tgl_r;
        end
    end

    // ------------------------------------------------
    // Checks
    // ------------------------------------------------
    sequence s_e_done;
        ph_r == erw_pkg::PH_E && cnt_z && rdy_ok;
    endsequence
    property p_capture;
        @(posedge link_clk) disable iff (!lrst_n_r)
        s_e_done ##0 rnw_r |=> bus_rd_n && rdata_l_r == $past(bus_din);
    endproperty
    a_capture: assert property (p_capture) // RL1
        else $error("read data not captured at strobe rise");
    property p_addr_hold;
        @(posedge link_clk) disable iff (!lrst_n_r)
        !bus_rd_n |=> $stable(bus_addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold) // RL2
        else $error("address moved during read strobe");
    property p_wait;
        @(posedge link_clk) disable iff (!lrst_n_r)
        e_wait |=> ph_r == erw_pkg::PH_E
        && wcnt_l_r == $past(wcnt_l_r) + 8'h01;
    endproperty
    a_wait: assert property (p_wait) // RL11
        else $error("waitstate not inserted");
    property p_end;
        @(posedge link_clk) disable iff (!lrst_n_r)
        s_e_done |=> ph_r != erw_pkg::PH_E ##0 bus_rd_n && bus_wr_n;
    endproperty
    a_end: assert property (p_end) // RL12
        else $error("cycle not ended on active ready");
    property p_min_access;
        @(posedge link_clk) disable iff (!lrst_n_r)
        ph_r == erw_pkg::PH_E && !cnt_z |=> ph_r == erw_pkg::PH_E;
    endproperty
    a_min_access: assert property (p_min_access) // RL16
        else $error("access phase cut short");
    property p_async_late;
        @(posedge link_clk) disable iff (!lrst_n_r)
        ph_r == erw_pkg::PH_E && cnt_z && rdy_en && rdy_async
        |-> rdy_ok == ($past(bus_ready, 2) == rdy_pol);
    endproperty
    a_async_late: assert property (p_async_late) // RL13
        else $error("async sample not one stage later");
    property p_start;
        @(posedge link_clk) disable iff (!lrst_n_r)
        start_p && ph_r == erw_pkg::PH_IDLE
        |=> ph_r == erw_pkg::PH_AB ##1 !bus_cs_n;
    endproperty
    a_start: assert property (p_start) // RL14
        else $error("cycle did not enter address phase");
    property p_polarity;
        @(posedge link_clk) disable iff (!lrst_n_r)
        ph_r == erw_pkg::PH_E && cnt_z && rdy_en && !rdy_async
        && rdy_s_r != rdy_pol |=> ph_r == erw_pkg::PH_E;
    endproperty
    a_polarity: assert property (p_polarity) // RL4
        else $error("inactive ready level ended the cycle");
endmodule : erw_ready_ctrl
`default_nettype wire

// ---- erw_ext_mem.sv ----
// Behavioural external memory answering bus cycles with READY and data
`timescale 1ns/1ps
`default_nettype none
module erw_ext_mem (
    // Bus from the device
    input wire logic ref_clk,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [23:0] addr,
    input wire logic [15:0] dout,
    input wire logic doe_n,
    // Bus to the device
    output logic [15:0] din,
    output logic ready,
    // Bench control and observation
    input wire logic [3:0] dly,
    input wire logic pol,
    output logic [15:0] wr_seen
);
    logic [3:0] cnt_r = 4'h0;
    logic rdy_r = 1'b0;
    logic strobe;
    logic [15:0] pat;
    // ------------------------------------------------
    // Data and READY
    // ------------------------------------------------
    assign strobe = !cs_n && (!rd_n || !wr_n);
    assign pat = addr[15:0] ^ 16'h3c3c;
    // Inverse once released, so late capture never matches
    assign din = !rd_n ? pat : ~pat;
    assign ready = pol ? rdy_r : !rdy_r;
    // Driven on the reference clock, held to strobe end
    always @(posedge ref_clk)
    begin
        cnt_r <= strobe ? cnt_r + {3'h0, cnt_r != 4'hf} : 4'h0;
        rdy_r <= strobe && (cnt_r >= dly);
        if (!wr_n && !doe_n)
            wr_seen <= dout;
    end
endmodule : erw_ext_mem
`default_nettype wire

// ---- erw_ready_ctrl_tb.sv ----
// Self-checking bench for the READY wait control block
`timescale 1ns/1ps
`default_nettype none
module erw_ready_ctrl_tb;
    logic aclk, aresetn, link_clk, bus_reference_clock;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb, dly;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, pol;
    logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
    logic bus_cs_n, bus_rd_n, bus_wr_n, bus_doe_n, bus_ready;
    logic [23:0] bus_addr, st_addr;
    logic [15:0] bus_dout, bus_din, wr_seen;
    logic [7:0] ws, ws_a;
    int err_total, cmp_count, wd_cnt, cs_cnt, st_cnt;
    logic [10:0] tm_tab [4] = '{11'h000, 11'h7ff, 11'h254, 11'h41b};

    erw_ready_ctrl uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_clk,
        .bus_reference_clock, .bus_cs_n, .bus_rd_n, .bus_wr_n, .bus_addr,
        .bus_dout, .bus_doe_n, .bus_din, .bus_ready);
    erw_ext_mem mem (.ref_clk(bus_reference_clock), .cs_n(bus_cs_n),
        .rd_n(bus_rd_n), .wr_n(bus_wr_n), .addr(bus_addr), .dout(bus_dout),
        .doe_n(bus_doe_n), .din(bus_din), .ready(bus_ready), .dly(dly),
        .pol(pol), .wr_seen(wr_seen));
    // ------------------------------------------------
    // Clocks, bus monitor, watchdog
    // ------------------------------------------------
    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    initial
    begin
        link_clk = 1'b0;
        #37;
        forever #80 link_clk = ~link_clk;
    end
    always @(posedge link_clk)
    begin
        if (bus_cs_n === 1'b0)
            cs_cnt++;
        if (bus_rd_n === 1'b0 || bus_wr_n === 1'b0)
        begin
            st_cnt++;
            st_addr = bus_addr;
        end
    end
    always @(posedge aclk)
    begin
        wd_cnt++;
        if (wd_cnt == 90000)
        begin
            err_total++;
            test_done();
        end
    end
    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done
    task automatic check(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
            err_total++;
        end
    endtask : check
    task automatic chk_resp(input string nm, input logic [1:0] exp);
        check(nm, {30'h0, last_resp}, {30'h0, exp});
    endtask : chk_resp
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            if (!aw_ok && s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (!w_ok && s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
            aw_ok = aw_ok || s_axi_awready === 1'b1;
            w_ok = w_ok || s_axi_wready === 1'b1;
        end
        while (s_axi_bvalid !== 1'b1)
            @(posedge aclk);
        last_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        while (s_axi_arready !== 1'b1)
            @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
        while (s_axi_rvalid !== 1'b1)
            @(posedge aclk);
        d = s_axi_rdata;
        last_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_rd
    function automatic logic [31:0] ph_len(input logic [10:0] t);
        return 32'(t[0]) + 32'(t[2:1]) + 32'(t[3]) + 32'(t[8:4])
            + 32'(t[10:9]) + 32'h2;
    endfunction : ph_len
    task automatic bus_op(input logic [2:0] ctl, input logic [10:0] tm,
        input logic rnw, input logic [23:0] a);
        axi_wr(erw_pkg::OFS_CTRL, {29'h0, ctl});
        axi_wr(erw_pkg::OFS_TIMING, {21'h0, tm});
        axi_wr(erw_pkg::OFS_ADDR, {8'h0, a});
        axi_wr(erw_pkg::OFS_WDATA, {16'h0, ~a[15:0]});
        cs_cnt = 0;
        st_cnt = 0;
        axi_wr(erw_pkg::OFS_CMD, {31'h0, rnw});
        axi_wr(erw_pkg::OFS_ADDR, 32'h0);
        chk_resp("busy write resp", erw_pkg::RESP_SLVERR);
        rv = 32'h1;
        while (rv[erw_pkg::ST_BUSY])
            axi_rd(erw_pkg::OFS_STATUS, rv);
        ws = rv[15:8];
        check("strobe addr", {8'h0, st_addr}, {8'h0, a});
        check("strobe len", st_cnt, 32'(tm[8:4]) + 32'(ws) + 1);
        check("select len", cs_cnt, ph_len(tm) + 32'(ws));
        axi_rd(erw_pkg::OFS_RDATA, rv);
        if (rnw)
            check("read data", rv, {16'h0, a[15:0] ^ 16'h3c3c});
        else
            check("write data", {16'h0, wr_seen}, {16'h0, ~a[15:0]});
    endtask : bus_op
    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial
    begin
        aresetn = 1'b0;
        s_axi_awaddr = 8'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 8'h0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        dly = 4'h9;
        pol = 1'b1;
        // Link side needs the reset for several of its own periods
        repeat (8) @(posedge link_clk);
        @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge link_clk);
        @(posedge aclk);
        axi_rd(erw_pkg::OFS_CTRL, rv);
        check("ctrl reset", rv, {29'h0, erw_pkg::CTRL_RST});
        axi_rd(erw_pkg::OFS_TIMING, rv);
        check("timing reset", rv, {21'h0, erw_pkg::TIMING_RST});
        axi_rd(8'h1c, rv);
        chk_resp("unmapped rd resp", erw_pkg::RESP_SLVERR);
        check("unmapped rd data", rv, 32'h0);
        axi_wr(8'h1c, 32'h1);
        chk_resp("unmapped wr resp", erw_pkg::RESP_SLVERR);
        axi_wr(erw_pkg::OFS_STATUS, 32'hff);
        chk_resp("status wr resp", erw_pkg::RESP_SLVERR);
        axi_wr(erw_pkg::OFS_CTRL, 32'h5);
        chk_resp("ctrl wr resp", erw_pkg::RESP_OKAY);
        axi_rd(erw_pkg::OFS_CTRL, rv);
        check("ctrl readback", rv, 32'h5);
        // Only the low byte lane may land
        s_axi_wstrb <= 4'h1;
        axi_wr(erw_pkg::OFS_TIMING, 32'h7ff);
        axi_rd(erw_pkg::OFS_TIMING, rv);
        check("timing lane", rv, 32'h0ff);
        // Command without lane 0 must not start a cycle
        s_axi_wstrb <= 4'h2;
        axi_wr(erw_pkg::OFS_CMD, 32'h1);
        axi_rd(erw_pkg::OFS_STATUS, rv);
        check("cmd lane", rv, 32'h0);
        s_axi_wstrb <= 4'hf;
        $display("register test done");
        // READY active but disabled: phase lengths only
        for (int i = 0; i < 4; i++)
        begin
            bus_op(3'h0, tm_tab[i], i[0] == 1'b0, {20'h00a5c, i[3:0]});
            check("ignored ready", {24'h0, ws}, 32'h0);
        end
        $display("phase test done");
        dly <= 4'h2;
        bus_op(3'h3, 11'h000, 1'b1, 24'h001234);
        ws_a = ws;
        check("waitstate seen", {31'h0, ws_a == 8'h0}, 32'h0);
        dly <= 4'h4;
        bus_op(3'h3, 11'h000, 1'b0, 24'h004321);
        check("two more waits", {24'h0, ws}, {24'h0, ws_a + 8'h2});
        dly <= 4'h2;
        pol <= 1'b0;
        bus_op(3'h1, 11'h000, 1'b1, 24'h00beef);
        check("low polarity", {24'h0, ws}, {24'h0, ws_a});
        pol <= 1'b1;
        bus_op(3'h7, 11'h000, 1'b1, 24'h00cafe);
        check("async later", {24'h0, ws}, {24'h0, ws_a + 8'h1});
        dly <= 4'h0;
        bus_op(3'h7, 11'h000, 1'b0, 24'h000f0f);
        check("async min wait", {31'h0, ws == 8'h0}, 32'h0);
        bus_op(3'h3, 11'h020, 1'b1, 24'h00f0f0);
        check("sync no wait", {24'h0, ws}, 32'h0);
        $display("ready test done");
        test_done();
    end
endmodule : erw_ready_ctrl_tb
`default_nettype wire
